// >>> common/kscan_pkg.sv
package kscan_pkg;
    localparam int SYS_CLK_KHZ = 250000;
    localparam int SCAN_CLK_KHZ = 128;
    localparam int TICK_CYC = SYS_CLK_KHZ / SCAN_CLK_KHZ;
    localparam int GLITCH_NS = 1000;
    localparam int GLITCH_CYC = (GLITCH_NS * (SYS_CLK_KHZ / 1000) + 999) / 1000;
    localparam int MAX_ROWS = 8;
    localparam int MAX_COLS = 20;
    localparam int KEY_BUF_DEPTH = 16;
    localparam int MOD_KEYS = 4;
    localparam int CODE_W = 8;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] STAT_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] DATA_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] MODK_OFS = 8'h0c;
    localparam logic [ADDR_W-1:0] MODS_OFS = 8'h10;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_COL_LSB = 8;
    localparam int CTRL_COL_W = 5;
    localparam int CTRL_ROW_LSB = 16;
    localparam int CTRL_ROW_W = 4;
    localparam logic [31:0] CTRL_RST = 32'h0008_1400;
    localparam logic [31:0] MODK_RST = 32'hffff_ffff;
    localparam int STAT_GHOST_BIT = 0;
    localparam int STAT_OVF_BIT = 1;
    localparam int STAT_AVAIL_BIT = 2;
    localparam int STAT_REQ_BIT = 3;
    localparam int STAT_CNT_LSB = 8;
    localparam int STAT_CNT_W = 5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_END} scan_state_t;
endpackage : kscan_pkg

// >>> dv/key_matrix_model.sv
`timescale 1ns/100ps
module key_matrix_model #(
    parameter int NROWS = 8,
    parameter int NCOLS = 20
) (
    input wire logic [NCOLS-1:0] col_drive,
    input wire logic [NCOLS*NROWS-1:0] pressed,
    output logic [NROWS-1:0] row_sense
);
    // open rows sit on pull-downs, so a released key reads low, never the last value
    always_comb begin
        row_sense = '0;
        for (int c = 0; c < NCOLS; c++) begin
            for (int r = 0; r < NROWS; r++) begin
                if (col_drive[c] && pressed[c*NROWS+r]) begin
                    row_sense[r] = 1'h1;
                end
            end
        end
    end
endmodule : key_matrix_model

// >>> dv/testbench.sv
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %0t mismatch got %h exp %h", $time, g, e); end end
module testbench;
    import kscan_pkg::*;
    logic CLK_SYS = 1'h0;
    logic RST = 1'h1;
    logic [7:0] AWADDR = '0, ARADDR = '0;
    logic AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
    logic [31:0] WDATA = '0;
    logic [3:0] WSTRB = '0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, CLK_REQ;
    logic [1:0] BRESP, RRESP, rsp;
    logic [31:0] RDATA, rd_d, modk;
    logic [19:0] COL_OUT;
    logic [7:0] ROW_IN;
    logic [159:0] pressed = '0, pk = '0;
    logic [3:0] st;
    int error_cnt = 0, checks_done = 0;
    bit ok;
    logic [7:0] exp_q[$];

    always #2 CLK_SYS = ~CLK_SYS;

    key_matrix_scanner dut_u (.CLK_SYS(CLK_SYS), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .COL_OUT(COL_OUT), .ROW_IN(ROW_IN), .CLK_REQ(CLK_REQ));
    key_matrix_model mdl_u (.col_drive(COL_OUT), .pressed(pressed), .row_sense(ROW_IN));

    function automatic logic [7:0] key_code(input int c, input int r, input int rows);
        return 8'(c * rows + r);
    endfunction : key_code

    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    // handshakes are judged at the falling edge, where inputs and outputs are settled
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        bit aw = 0, w = 0, b = 0;
        int n = 0;
        r = 2'h3;
        @(posedge CLK_SYS);
        AWADDR <= a;
        WDATA <= d;
        WSTRB <= s;
        AWVALID <= 1'h1;
        WVALID <= 1'h1;
        BREADY <= 1'h1;
        while (!b && n < 200) begin
            @(negedge CLK_SYS);
            aw = aw | (AWVALID & AWREADY);
            w = w | (WVALID & WREADY);
            b = BVALID;
            if (b) r = BRESP;
            @(posedge CLK_SYS);
            if (aw) AWVALID <= 1'h0;
            if (w) WVALID <= 1'h0;
            if (b) BREADY <= 1'h0;
            n++;
        end
        `CHK(b, 1'h1)
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ar = 0, t = 0;
        int n = 0;
        d = '0;
        r = 2'h3;
        @(posedge CLK_SYS);
        ARADDR <= a;
        ARVALID <= 1'h1;
        RREADY <= 1'h1;
        while (!t && n < 200) begin
            @(negedge CLK_SYS);
            ar = ar | (ARVALID & ARREADY);
            t = RVALID;
            if (t) d = RDATA;
            if (t) r = RRESP;
            @(posedge CLK_SYS);
            if (ar) ARVALID <= 1'h0;
            if (t) RREADY <= 1'h0;
            n++;
        end
        `CHK(t, 1'h1)
    endtask : rd

    task automatic chk(input logic [7:0] a, input logic [31:0] e);
        rd(a, rd_d, rsp);
        `CHK({rsp, rd_d}, {RESP_OKAY, e})
    endtask : chk

    task automatic req_wait(input logic v, input int lim, output bit hit);
        hit = 0;
        for (int i = 0; i < lim && !hit; i++) begin
            @(negedge CLK_SYS);
            hit = (CLK_REQ === v);
        end
    endtask : req_wait

    // scan-end is the only cycle with the request up and every column high
    task automatic pass_end();
        bit f = 0;
        int n = 0;
        while (!f && n < 25000) begin
            @(negedge CLK_SYS);
            `CHK(1'($onehot(COL_OUT) || (&COL_OUT)), 1'h1)
            f = CLK_REQ && (&COL_OUT);
            n++;
        end
        `CHK(f, 1'h1)
    endtask : pass_end

    initial begin
        // about 80k cycles of scan passes are expected
        repeat (95000) @(posedge CLK_SYS);
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        wrap_up();
    end

    initial begin
        void'($urandom(4));
        repeat (3) @(posedge CLK_SYS);
        RST <= 1'h0;
        @(negedge CLK_SYS);
        `CHK(COL_OUT, 20'hfffff)
        `CHK(CLK_REQ, 1'h0)
        chk(CTRL_OFS, CTRL_RST);
        chk(MODK_OFS, MODK_RST);
        chk(STAT_OFS, 32'h0);
        chk(DATA_OFS, 32'h0);
        rd(8'h14 + 8'(4 * $urandom_range(57)), rd_d, rsp);
        `CHK({rsp, rd_d}, {RESP_SLVERR, 32'h0})
        wr(8'h14 + 8'(4 * $urandom_range(57)), 32'h1, 4'hf, rsp);
        `CHK(rsp, RESP_SLVERR)
        modk = MODK_RST;
        repeat (4) begin
            rd_d = $urandom();
            st = 4'($urandom_range(15));
            wr(MODK_OFS, rd_d, st, rsp);
            for (int i = 0; i < 4; i++) if (st[i]) modk[8*i+:8] = rd_d[8*i+:8];
            chk(MODK_OFS, modk);
        end
        wr(MODK_OFS, MODK_RST, 4'hf, rsp);
        @(posedge CLK_SYS);
        pressed <= 160'h1;
        req_wait(1'h1, 600, ok);
        `CHK(ok, 1'h0)
        @(posedge CLK_SYS);
        pressed <= '0;
        repeat (300) @(posedge CLK_SYS);
        // ghost: column 0 has two hits, so row 0 in column 1 is locked out
        wr(CTRL_OFS, 32'h0002_0201, 4'hf, rsp);
        @(posedge CLK_SYS);
        pressed <= 160'h103;
        req_wait(1'h1, 400, ok);
        `CHK(ok, 1'h1)
        pass_end();
        @(posedge CLK_SYS);
        pressed <= '0;
        pass_end();
        req_wait(1'h0, 4, ok);
        `CHK(ok, 1'h1)
        chk(STAT_OFS, 32'h0000_0205);
        chk(DATA_OFS, {24'h0, key_code(0, 0, 2)});
        chk(DATA_OFS, {24'h0, key_code(0, 1, 2)});
        chk(DATA_OFS, 32'h0);
        wr(STAT_OFS, 32'h1, 4'h1, rsp);
        chk(STAT_OFS, 32'h0);
        @(posedge CLK_SYS);
        pressed <= 160'h1;
        repeat (100) @(posedge CLK_SYS);
        pressed <= '0;
        req_wait(1'h1, 500, ok);
        `CHK(ok, 1'h0)
        // ten columns, one row, key 3 a modifier: two presses give 18 codes
        wr(MODK_OFS, 32'hffff_ff03, 4'hf, rsp);
        wr(CTRL_OFS, 32'h0001_0a01, 4'hf, rsp);
        for (int c = 0; c < 10; c++) pk[c*8] = 1'h1;
        @(posedge CLK_SYS);
        pressed <= pk;
        pass_end();
        @(posedge CLK_SYS);
        pressed <= '0;
        chk(MODS_OFS, 32'h1);
        pass_end();
        req_wait(1'h0, 4, ok);
        `CHK(ok, 1'h1)
        chk(MODS_OFS, 32'h0);
        @(posedge CLK_SYS);
        pressed <= pk;
        pass_end();
        wr(CTRL_OFS, 32'h0001_0a00, 4'hf, rsp);
        req_wait(1'h1, 600, ok);
        `CHK(ok, 1'h0)
        @(posedge CLK_SYS);
        pressed <= '0;
        chk(STAT_OFS, 32'h0000_1006);
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 10; c++) begin
                if (c != 3 && exp_q.size() < 16) exp_q.push_back(key_code(c, 0, 1));
            end
        end
        foreach (exp_q[i]) chk(DATA_OFS, {24'h0, exp_q[i]});
        chk(DATA_OFS, 32'h0);
        wr(STAT_OFS, 32'h2, 4'h1, rsp);
        chk(STAT_OFS, 32'h0);
        wrap_up();
    end
endmodule : testbench

// >>> rtl/key_matrix_scanner.sv
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
module key_matrix_scanner #(
    parameter int NROWS = kscan_pkg::MAX_ROWS,
    parameter int NCOLS = kscan_pkg::MAX_COLS,
    parameter int BUF_DEPTH = kscan_pkg::KEY_BUF_DEPTH
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic [kscan_pkg::ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [kscan_pkg::ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    output logic [NCOLS-1:0] COL_OUT,
    input wire logic [NROWS-1:0] ROW_IN,
    output logic CLK_REQ
);
    import kscan_pkg::*;

    localparam int RW = $clog2(NROWS);
    localparam int CLW = $clog2(NCOLS);
    localparam int NKEYS = NROWS * NCOLS;
    localparam int PW = $clog2(BUF_DEPTH);
    localparam int CW = $clog2(BUF_DEPTH + 1);
    localparam int TW = $clog2(TICK_CYC);
    localparam int FW = $clog2(GLITCH_CYC);

    // row input synchroniser and glitch filter
    logic [NROWS-1:0] row_s1_r, row_s2_r, row_s3_r, row_flt_r;
    logic [FW-1:0] flt_cnt_r;
    wire row_agree = row_s2_r == row_s3_r;
    wire row_diff = row_agree && (row_s3_r != row_flt_r);
    wire flt_done = row_diff && (flt_cnt_r == FW'(GLITCH_CYC - 1));
    // any disagreement restarts the window, so short glitches never reach the scan
    wire [FW-1:0] flt_cnt_nxt = (row_diff && !flt_done) ? FW'(flt_cnt_r + 1'b1) : '0;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            row_s1_r <= '0;
            row_s2_r <= '0;
            row_s3_r <= '0;
            row_flt_r <= '0;
            flt_cnt_r <= '0;
        end else begin
            row_s1_r <= ROW_IN;
            row_s2_r <= row_s1_r;
            row_s3_r <= row_s2_r;
            flt_cnt_r <= flt_cnt_nxt;
            if (flt_done) begin
                row_flt_r <= row_s3_r;
            end
        end
    end

    // configuration
    logic [31:0] ctrl_r, modk_r;
    wire ctrl_en = ctrl_r[CTRL_EN_BIT];
    wire [CTRL_ROW_W-1:0] rows_f = ctrl_r[CTRL_ROW_LSB +: CTRL_ROW_W];
    wire [CTRL_COL_W-1:0] cols_f = ctrl_r[CTRL_COL_LSB +: CTRL_COL_W];
    // out-of-range counts are clamped rather than refused
    wire [CTRL_ROW_W-1:0] rows_eff = (rows_f == '0) ? CTRL_ROW_W'(1) :
        (rows_f > CTRL_ROW_W'(NROWS)) ? CTRL_ROW_W'(NROWS) : rows_f;
    wire [CTRL_COL_W-1:0] cols_eff = (cols_f == '0) ? CTRL_COL_W'(1) :
        (cols_f > CTRL_COL_W'(NCOLS)) ? CTRL_COL_W'(NCOLS) : cols_f;
    wire [NROWS-1:0] row_mask = ~({NROWS{1'b1}} << rows_eff);

    // scan clock request and 128 kHz step
    scan_state_t state_r, state_nxt;
    logic clk_req_r;
    logic [TW-1:0] tick_cnt_r;
    wire tick = clk_req_r && (tick_cnt_r == TW'(TICK_CYC - 1));
    wire [TW-1:0] tick_nxt = (!clk_req_r || tick) ? '0 : TW'(tick_cnt_r + 1'b1);
    wire clk_req_nxt = state_nxt != ST_IDLE;

    // scan counters
    logic [RW-1:0] row_cnt_r, row_cnt_nxt;
    logic [CLW-1:0] col_cnt_r, col_cnt_nxt;
    logic [CODE_W-1:0] key_idx_r, key_idx_nxt;
    logic [NROWS-1:0] row_hit_r, row_hit_nxt, col_hits_r, col_hits_nxt;
    logic any_key_r, any_key_nxt;
    logic [MOD_KEYS-1:0] mod_live_r, mod_live_nxt, mod_stat_r, mod_hit;
    logic [NKEYS-1:0] seen_r;
    logic [NCOLS-1:0] col_out_r;

    wire step = (state_r == ST_SCAN) && tick;
    wire row_last = CTRL_ROW_W'(row_cnt_r) == rows_eff - 1'b1;
    wire col_last = CTRL_COL_W'(col_cnt_r) == cols_eff - 1'b1;
    wire pressed = row_flt_r[row_cnt_r];
    wire [NROWS-1:0] row_bit = NROWS'(1) << row_cnt_r;
    wire [NROWS-1:0] col_now = col_hits_r | (pressed ? row_bit : '0);
    wire multi = |(col_now & (col_now - 1'b1));
    wire ghost_hit = step && pressed && row_hit_r[row_cnt_r];
    wire was_seen = seen_r[key_idx_r];
    wire is_mod = |mod_hit;
    // a non-modifier key in a row already marked by an earlier multi-hit column is withheld, everything else rolls over
    wire new_key = step && pressed && !was_seen && !ghost_hit;
    wire push_req = new_key && !is_mod;
    wire wake = ctrl_en && |(row_flt_r & row_mask);

    always_comb begin
        for (int i = 0; i < MOD_KEYS; i++) begin
            mod_hit[i] = modk_r[i*CODE_W +: CODE_W] == key_idx_r;
        end
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (wake) begin
                    state_nxt = ST_SCAN;
                end
            end
            ST_SCAN: begin
                if (!ctrl_en) begin
                    state_nxt = ST_IDLE;
                end else if (step && row_last && col_last) begin
                    state_nxt = ST_END;
                end
            end
            ST_END: begin
                state_nxt = (ctrl_en && any_key_r) ? ST_SCAN : ST_IDLE;
            end
        endcase
    end

    always_comb begin
        row_cnt_nxt = row_cnt_r;
        col_cnt_nxt = col_cnt_r;
        key_idx_nxt = key_idx_r;
        row_hit_nxt = row_hit_r;
        col_hits_nxt = col_hits_r;
        any_key_nxt = any_key_r;
        mod_live_nxt = mod_live_r;
        if (state_r != ST_SCAN) begin
            // every pass starts from a clean slate
            row_cnt_nxt = '0;
            col_cnt_nxt = '0;
            key_idx_nxt = '0;
            row_hit_nxt = '0;
            col_hits_nxt = '0;
            any_key_nxt = 1'b0;
            mod_live_nxt = '0;
        end else if (step) begin
            key_idx_nxt = CODE_W'(key_idx_r + 1'b1);
            any_key_nxt = any_key_r | pressed;
            if (pressed && is_mod) begin
                mod_live_nxt = mod_live_r | mod_hit;
            end
            if (row_last) begin
                row_cnt_nxt = '0;
                col_cnt_nxt = CLW'(col_cnt_r + 1'b1);
                col_hits_nxt = '0;
                if (multi) begin
                    row_hit_nxt = row_hit_r | col_now;
                end
            end else begin
                row_cnt_nxt = RW'(row_cnt_r + 1'b1);
                col_hits_nxt = col_now;
            end
        end
    end

    // selected column high, rest low; idle and scan-end drive all high
    wire [NCOLS-1:0] col_out_nxt = (state_nxt == ST_SCAN) ? (NCOLS'(1) << col_cnt_nxt) : '1;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state_r <= ST_IDLE;
            clk_req_r <= 1'b0;
            tick_cnt_r <= '0;
            col_out_r <= '1;
        end else begin
            state_r <= state_nxt;
            clk_req_r <= clk_req_nxt;
            tick_cnt_r <= tick_nxt;
            col_out_r <= col_out_nxt;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            row_cnt_r <= '0;
            col_cnt_r <= '0;
            key_idx_r <= '0;
            row_hit_r <= '0;
            col_hits_r <= '0;
            any_key_r <= 1'b0;
            mod_live_r <= '0;
        end else begin
            row_cnt_r <= row_cnt_nxt;
            col_cnt_r <= col_cnt_nxt;
            key_idx_r <= key_idx_nxt;
            row_hit_r <= row_hit_nxt;
            col_hits_r <= col_hits_nxt;
            any_key_r <= any_key_nxt;
            mod_live_r <= mod_live_nxt;
        end
    end

    // per-key memory of the previous pass, so a held key is buffered once
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            seen_r <= '0;
            mod_stat_r <= '0;
        end else begin
            if (state_r == ST_IDLE) begin
                seen_r <= '0;
            end else if (step) begin
                seen_r[key_idx_r] <= pressed;
            end
            if (state_r == ST_END) begin
                mod_stat_r <= mod_live_r;
            end
        end
    end

    // key-code buffer
    logic [CODE_W-1:0] buf_r [BUF_DEPTH];
    logic [PW-1:0] wp_r, rp_r;
    logic [CW-1:0] cnt_r;
    logic ghost_r, ovf_r;
    logic rd_take, rd_data;
    wire full = cnt_r == CW'(BUF_DEPTH);
    wire empty = cnt_r == '0;
    wire push_ok = push_req && !full;
    wire pop = rd_take && rd_data && !empty;
    wire [CW-1:0] cnt_nxt = CW'(cnt_r + CW'(push_ok) - CW'(pop));

    always_ff @(posedge CLK_SYS) begin
        if (push_ok) begin
            buf_r[wp_r] <= key_idx_r;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= push_ok ? PW'(wp_r + 1'b1) : wp_r;
            rp_r <= pop ? PW'(rp_r + 1'b1) : rp_r;
            cnt_r <= cnt_nxt;
        end
    end

    // AXI4-Lite slave
    logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r, rdata_r, rd_word;
    logic [3:0] wstrb_r;
    logic [1:0] bresp_r, rresp_r;
    logic rd_hit;

    assign AWREADY = !aw_hold_r;
    assign WREADY = !w_hold_r;
    assign ARREADY = !rvalid_r;
    assign BVALID = bvalid_r;
    assign BRESP = bresp_r;
    assign RVALID = rvalid_r;
    assign RRESP = rresp_r;
    assign RDATA = rdata_r;
    assign COL_OUT = col_out_r;
    assign CLK_REQ = clk_req_r;

    wire aw_take = AWVALID && !aw_hold_r;
    wire w_take = WVALID && !w_hold_r;
    wire wr_go = aw_hold_r && w_hold_r && !bvalid_r;
    assign rd_take = ARVALID && !rvalid_r;
    wire [ADDR_W-1:0] wa = {awaddr_r[ADDR_W-1:2], 2'b00};
    wire [ADDR_W-1:0] ra = {ARADDR[ADDR_W-1:2], 2'b00};
    assign rd_data = ra == DATA_OFS;
    wire wr_ctrl = wr_go && (wa == CTRL_OFS);
    wire wr_modk = wr_go && (wa == MODK_OFS);
    wire wr_stat = wr_go && (wa == STAT_OFS) && wstrb_r[0];
    wire wr_hit = (wa == CTRL_OFS) || (wa == STAT_OFS) || (wa == DATA_OFS) ||
        (wa == MODK_OFS) || (wa == MODS_OFS);
    wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    wire [31:0] ctrl_nxt = wr_ctrl ? ((ctrl_r & ~wmask) | (wdata_r & wmask)) : ctrl_r;
    wire [31:0] modk_nxt = wr_modk ? ((modk_r & ~wmask) | (wdata_r & wmask)) : modk_r;
    // write-one-to-clear; a new event in the same cycle keeps the flag set
    wire ghost_nxt = ghost_hit || (ghost_r && !(wr_stat && wdata_r[STAT_GHOST_BIT]));
    wire ovf_nxt = (push_req && full) || (ovf_r && !(wr_stat && wdata_r[STAT_OVF_BIT]));

    always_comb begin
        rd_word = '0;
        rd_hit = 1'b1;
        unique case (ra)
            CTRL_OFS: rd_word = ctrl_r;
            STAT_OFS: begin
                rd_word[STAT_GHOST_BIT] = ghost_r;
                rd_word[STAT_OVF_BIT] = ovf_r;
                rd_word[STAT_AVAIL_BIT] = !empty;
                rd_word[STAT_REQ_BIT] = clk_req_r;
                rd_word[STAT_CNT_LSB +: STAT_CNT_W] = STAT_CNT_W'(cnt_r);
            end
            DATA_OFS: rd_word[CODE_W-1:0] = empty ? '0 : buf_r[rp_r];
            MODK_OFS: rd_word = modk_r;
            MODS_OFS: rd_word[MOD_KEYS-1:0] = mod_stat_r;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else begin
            aw_hold_r <= aw_take || (aw_hold_r && !wr_go);
            w_hold_r <= w_take || (w_hold_r && !wr_go);
            if (aw_take) begin
                awaddr_r <= AWADDR;
            end
            if (w_take) begin
                wdata_r <= WDATA;
                wstrb_r <= WSTRB;
            end
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= '0;
        end else begin
            bvalid_r <= wr_go || (bvalid_r && !BREADY);
            if (wr_go) begin
                bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            rvalid_r <= rd_take || (rvalid_r && !RREADY);
            if (rd_take) begin
                rdata_r <= rd_word;
                rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ctrl_r <= CTRL_RST;
            modk_r <= MODK_RST;
            ghost_r <= 1'b0;
            ovf_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            modk_r <= modk_nxt;
            ghost_r <= ghost_nxt;
            ovf_r <= ovf_nxt;
        end
    end

    // checks
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);

    idle_cols_a: assert property (state_r == ST_IDLE |-> &COL_OUT)
        else $error("columns not all high in idle");
    scan_col_a: assert property (state_r == ST_SCAN |-> $onehot(COL_OUT) && COL_OUT[col_cnt_r])
        else $error("scan column drive wrong");
    idle_clear_a: assert property (state_r == ST_IDLE |=> row_hit_r == '0 && key_idx_r == '0)
        else $error("row-hit or key index not cleared");
    wake_scan_a: assert property (state_r == ST_IDLE && wake |=> state_r == ST_SCAN && CLK_REQ)
        else $error("row activity did not start a scan");
    row_wrap_a: assert property (step && row_last && !col_last && ctrl_en |=>
        row_cnt_r == '0 && col_cnt_r == CLW'($past(col_cnt_r) + 1'b1))
        else $error("row wrap or column advance wrong");
    scan_end_a: assert property (step && row_last && col_last && ctrl_en |=> state_r == ST_END)
        else $error("terminal counts did not end scan");
    key_idx_a: assert property (step && ctrl_en |=> key_idx_r == CODE_W'($past(key_idx_r) + 1'b1))
        else $error("key index did not advance");
    row_hit_a: assert property (step && row_last && !multi && ctrl_en |=> row_hit_r == $past(row_hit_r))
        else $error("row-hit changed on single-hit column");
    ghost_a: assert property (ghost_hit |=> ghost_r ##1 ghost_r || $past(wr_stat))
        else $error("ghost flag not set");
    // request drops with the idle entry; a fresh wake may raise it again one cycle later
    end_ret_a: assert property (state_r == ST_END && !any_key_r |=> state_r == ST_IDLE && !CLK_REQ)
        else $error("scan-end did not return to idle");
    req_off_a: assert property (!ctrl_en |=> !CLK_REQ)
        else $error("clock request while disabled");
    ovf_a: assert property (push_req && full && !pop |=> ovf_r && cnt_r == $past(cnt_r))
        else $error("overflow not flagged or code stored");
    glitch_a: assert property ($changed(row_flt_r) |-> $past(flt_cnt_r) == FW'(GLITCH_CYC - 1))
        else $error("row filter changed too early");
    tick_a: assert property (tick |=> !tick [*8])
        else $error("scan step rate too fast");

    wake_c: cover property (state_r == ST_IDLE ##1 state_r == ST_SCAN);
    rescan_c: cover property (state_r == ST_END && any_key_r ##1 state_r == ST_SCAN);
    ghost_c: cover property (ghost_hit);
    ovf_c: cover property (push_req && full);
endmodule : key_matrix_scanner
